// ---- rtl/ebr_params.svh ----
// Register map, field positions, reset values and limits of the read engine
`ifndef EBR_PARAMS_SVH
`define EBR_PARAMS_SVH
`define EBR_OFF_CTRL 8'h00
`define EBR_OFF_UNIT 8'h04
`define EBR_OFF_SRC 8'h08
`define EBR_OFF_DST 8'h0C
`define EBR_OFF_CNT 8'h10
`define EBR_OFF_DIG 8'h14
`define EBR_OFF_STAT 8'h18
`define EBR_OFF_MADDR 8'h1C
`define EBR_OFF_MDATA 8'h20
`define EBR_CTRL_EN 0
`define EBR_CTRL_PULSE 1
`define EBR_CTRL_WIDE 2
`define EBR_CTRL_ACCEPT 3
`define EBR_CTRL_STALL 4
`define EBR_ST_BUSY 0
`define EBR_ST_DONE 1
`define EBR_ST_ERR 2
`define EBR_ST_PAUSED 3
`define EBR_ST_BUILTIN 4
`define EBR_CTRL_RST 5'h00
`define EBR_CNT_RST 15'h0001
`define EBR_CNT_MAX 15'h7FFF
`define EBR_CNT_MAX_W 15'h3FFF
`define EBR_BUF_MAX 15'h7FFE
`define EBR_BUF_MAX_W 15'h7FFD
`define EBR_DIG_MAX 4'h4
`define EBR_DIG_MAX_W 4'h8
`define EBR_SCAN_DIV 25000
`define EBR_RESP_OK 2'h0
`define EBR_RESP_SLVERR 2'h2
`endif

// ---- rtl/ebr_pkg.sv ----
// Types shared by the buffer read engine modules
package ebr_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_XFER = 2'b10
   } ebr_state_e;
   typedef struct packed {
      logic wide;
      logic [3:0] digits;
      logic [14:0] src;
      logic [14:0] dst;
      logic [14:0] words;
      logic [2:0] slot;
      logic bsel;
   } ebr_xfer_s;
endpackage : ebr_pkg

// ---- rtl/ebr_stream_if.sv ----
// Valid/ready word stream between the engine and its FIFO
`timescale 1ns/1ps
interface ebr_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : ebr_stream_if

// ---- rtl/ebr_fifo.sv ----
// Word FIFO between the expansion bus reads and local storage
`timescale 1ns/1ps
module ebr_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   ebr_stream_if.snk in_s,
   ebr_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
         $error("FIFO depth must be a power of two of at least 2");
      end
   endgenerate
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wp_q, wp_d, rp_q, rp_d;
   logic full, empty, push, pop;
   always_comb begin
      full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
      empty = (wp_q == rp_q);
      push = in_s.valid && !full;
      pop = out_s.ready && !empty;
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
   end
   assign in_s.ready = !full;
   assign out_s.valid = !empty;
   assign out_s.data = mem[rp_q[AW-1:0]];
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
      end
      if (push) begin
         mem[wp_q[AW-1:0]] <= in_s.data;
      end
   end
endmodule : ebr_fifo

// ---- rtl/ebr_wordmem.sv ----
// Local destination word storage with nibble-masked writes
`timescale 1ns/1ps
module ebr_wordmem #(
   parameter int AW = 10
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] wmask,
   input wire logic [AW-1:0] raddr,
   output logic [15:0] rdata
);
   logic [15:0] mem [1 << AW];
   // Bits outside the mask keep their old value, as for a digit group
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= (mem[waddr] & ~wmask) | (wdata & wmask);
      end
      rdata <= mem[raddr];
   end
endmodule : ebr_wordmem

// ---- rtl/ebr_engine.sv ----
// Extension buffer read engine with AXI4-Lite control
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ebr_params.svh"
module ebr_engine #(
   parameter int DST_AW = 10,
   parameter int FIFO_DEPTH = 16,
   parameter int SCAN_DIV = `EBR_SCAN_DIV
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic ext_req,
   output logic [2:0] ext_slot,
   output logic ext_builtin_sel,
   output logic [14:0] ext_addr,
   input wire logic ext_ack,
   input wire logic [15:0] ext_rdata,
   input wire logic irq_active,
   input wire logic in_isr,
   output logic irq_hold,
   input wire logic builtin_strap,
   output logic busy
);
   localparam int SW = $clog2(SCAN_DIV);
   generate
      if (DST_AW < 4 || DST_AW > 15 || SCAN_DIV < 2) begin : g_chk
         $error("Unsupported storage size or scan divider");
      end
   endgenerate

   function automatic logic [15:0] nib_mask(input logic [3:0] n);
      logic [15:0] m;
      m = 16'hFFFF;
      if (n < 4'h4) begin
         m = 16'((17'h00001 << {n, 2'b00}) - 17'h00001);
      end
      return m;
   endfunction : nib_mask

   function automatic logic [31:0] lane_mask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : lane_mask

   ebr_stream_if #(.W(16)) fin ();
   ebr_stream_if #(.W(16)) fout ();

   // Register file
   logic [4:0] ctrl_q, ctrl_d;
   logic [2:0] unit_q, unit_d;
   logic [14:0] src_q, src_d, dst_q, dst_d, cnt_q, cnt_d, maddr_q, maddr_d;
   logic [3:0] dig_q, dig_d;
   logic done_q, done_d, err_q, err_d;
   // Bus slave
   logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic rvalid_q, rvalid_d;
   logic do_wr, wr_hit;
   logic [31:0] wr_m, wr_v;
   // Engine
   ebr_pkg::ebr_state_e st_q, st_d;
   ebr_pkg::ebr_xfer_s x_q, x_d;
   logic [14:0] iss_q, iss_d, wr_q, wr_d, ea_q, ea_d, words;
   logic req_q, req_d, en_prev_q, start, cfg_ok, paused;
   logic [SW-1:0] scan_q, scan_d;
   logic scan_tick;
   logic [15:0] mem_mask, mem_rdata;
   logic mem_we;
   logic [15:0] dst_end;
   logic s1_q, s2_q, s3_q, armed_q, builtin_q;
   logic [1:0] fill_q;

   // Strap pin: three stages, caught once the last two agree after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         fill_q <= 2'h0;
         armed_q <= 1'b0;
         builtin_q <= 1'b0;
      end else begin
         s1_q <= builtin_strap;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // Reset zeros still in the stages must not pass for the pin
         if (fill_q != 2'h3) begin
            fill_q <= fill_q + 2'h1;
         end
         if (!armed_q && fill_q == 2'h3 && s2_q == s3_q) begin
            armed_q <= 1'b1;
            builtin_q <= s3_q;
         end
      end
   end

   // AXI4-Lite slave: address and data taken in either order
   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d = w_have_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      do_wr = aw_have_q && w_have_q && !bvalid_q;
      wr_m = lane_mask(wstrb_q);
      wr_v = wdata_q & wr_m;
      unique case (awaddr_q)
         `EBR_OFF_CTRL, `EBR_OFF_UNIT, `EBR_OFF_SRC, `EBR_OFF_DST,
         `EBR_OFF_CNT, `EBR_OFF_DIG, `EBR_OFF_STAT, `EBR_OFF_MADDR:
            wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
      if (do_wr) begin
         aw_have_d = 1'b0;
         w_have_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = wr_hit ? `EBR_RESP_OK : `EBR_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d = `EBR_RESP_OK;
         unique case (s_axi_araddr)
            `EBR_OFF_CTRL: rdata_d = {27'h0, ctrl_q};
            `EBR_OFF_UNIT: rdata_d = {29'h0, unit_q};
            `EBR_OFF_SRC: rdata_d = {17'h0, src_q};
            `EBR_OFF_DST: rdata_d = {17'h0, dst_q};
            `EBR_OFF_CNT: rdata_d = {17'h0, cnt_q};
            `EBR_OFF_DIG: rdata_d = {28'h0, dig_q};
            `EBR_OFF_STAT: rdata_d = {27'h0, builtin_q, paused, err_q,
                                      done_q, busy};
            `EBR_OFF_MADDR: rdata_d = {17'h0, maddr_q};
            `EBR_OFF_MDATA: rdata_d = {16'h0, mem_rdata};
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = `EBR_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   assign s_axi_awready = !aw_have_q && !bvalid_q;
   assign s_axi_wready = !w_have_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `EBR_RESP_OK;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `EBR_RESP_OK;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // Engine and register file
   always_comb begin
      ctrl_d = ctrl_q;
      unit_d = unit_q;
      src_d = src_q;
      dst_d = dst_q;
      cnt_d = cnt_q;
      dig_d = dig_q;
      maddr_d = maddr_q;
      done_d = done_q;
      err_d = err_q;
      st_d = st_q;
      x_d = x_q;
      iss_d = iss_q;
      wr_d = wr_q;
      req_d = req_q;
      ea_d = ea_q;
      scan_d = (scan_q == SW'(SCAN_DIV - 1)) ? '0 : scan_q + 1'b1;
      scan_tick = (scan_q == SW'(SCAN_DIV - 1));
      if (do_wr) begin
         unique case (awaddr_q)
            `EBR_OFF_CTRL: ctrl_d = (ctrl_q & ~wr_m[4:0]) | wr_v[4:0];
            `EBR_OFF_UNIT: unit_d = (unit_q & ~wr_m[2:0]) | wr_v[2:0];
            `EBR_OFF_SRC: src_d = (src_q & ~wr_m[14:0]) | wr_v[14:0];
            `EBR_OFF_DST: dst_d = (dst_q & ~wr_m[14:0]) | wr_v[14:0];
            `EBR_OFF_CNT: cnt_d = (cnt_q & ~wr_m[14:0]) | wr_v[14:0];
            `EBR_OFF_DIG: dig_d = (dig_q & ~wr_m[3:0]) | wr_v[3:0];
            `EBR_OFF_STAT: begin
               if (wr_v[`EBR_ST_DONE]) begin
                  done_d = 1'b0;
               end
               if (wr_v[`EBR_ST_ERR]) begin
                  err_d = 1'b0;
               end
            end
            `EBR_OFF_MADDR: maddr_d = (maddr_q & ~wr_m[14:0]) | wr_v[14:0];
            default: ;
         endcase
      end
      // Pulsed form fires once per enable rise, plain form once per scan
      start = ctrl_q[`EBR_CTRL_EN] && (ctrl_q[`EBR_CTRL_PULSE]
              ? !en_prev_q : scan_tick);
      words = ctrl_q[`EBR_CTRL_WIDE] ? {cnt_q[13:0], 1'b0} : cnt_q;
      dst_end = {1'b0, dst_q} + {1'b0, words};
      cfg_ok = (cnt_q != 15'h0000)
         && (ctrl_q[`EBR_CTRL_WIDE]
             ? (cnt_q <= `EBR_CNT_MAX_W && src_q <= `EBR_BUF_MAX_W)
             : (cnt_q <= `EBR_CNT_MAX && src_q <= `EBR_BUF_MAX))
         && (dig_q <= (ctrl_q[`EBR_CTRL_WIDE] ? `EBR_DIG_MAX_W
                                              : `EBR_DIG_MAX))
         && (dst_end <= 16'(1 << DST_AW))
         // Inside a service routine only when interrupts are held off
         && !(in_isr && ctrl_q[`EBR_CTRL_ACCEPT]);
      paused = (st_q == ebr_pkg::ST_XFER) && ctrl_q[`EBR_CTRL_ACCEPT]
               && irq_active;
      unique case (st_q)
         ebr_pkg::ST_IDLE: begin
            if (start && cfg_ok) begin
               st_d = ebr_pkg::ST_XFER;
               x_d.wide = ctrl_q[`EBR_CTRL_WIDE];
               x_d.digits = dig_q;
               x_d.src = src_q;
               x_d.dst = dst_q;
               x_d.words = words;
               // Built-in master takes index 0, externals shift up
               x_d.bsel = builtin_q && (unit_q == 3'h0);
               x_d.slot = builtin_q ? unit_q - 3'h1 : unit_q;
               iss_d = 15'h0000;
               wr_d = 15'h0000;
            end else if (start) begin
               err_d = 1'b1;
            end
         end
         ebr_pkg::ST_XFER: begin
            if (req_q && ext_ack) begin
               req_d = 1'b0;
               iss_d = iss_q + 15'h0001;
            end else if (!req_q && iss_q != x_q.words && fin.ready
                         && !paused) begin
               // Only one word in flight, so a free slot covers the answer
               req_d = 1'b1;
               ea_d = x_q.src + iss_q;
            end
            if (mem_we) begin
               wr_d = wr_q + 15'h0001;
            end
            if (wr_q == x_q.words) begin
               st_d = ebr_pkg::ST_IDLE;
               done_d = 1'b1;
            end
         end
         default: st_d = ebr_pkg::ST_IDLE;
      endcase
   end

   // Word pairs land low half first; digit groups mask per half
   always_comb begin
      mem_we = fout.valid && fout.ready;
      if (x_q.digits == 4'h0) begin
         mem_mask = 16'hFFFF;
      end else if (x_q.wide && wr_q[0]) begin
         mem_mask = (x_q.digits > 4'h4) ? nib_mask(x_q.digits - 4'h4)
                                         : 16'h0000;
      end else begin
         mem_mask = nib_mask(x_q.digits);
      end
   end

   assign fin.valid = req_q && ext_ack;
   assign fin.data = ext_rdata;
   // Software stall on the drain lets the FIFO really fill
   assign fout.ready = (st_q == ebr_pkg::ST_XFER)
                       && !ctrl_q[`EBR_CTRL_STALL];
   assign busy = (st_q == ebr_pkg::ST_XFER);
   assign irq_hold = busy && !ctrl_q[`EBR_CTRL_ACCEPT];
   assign ext_req = req_q;
   assign ext_addr = ea_q;
   assign ext_slot = x_q.slot;
   assign ext_builtin_sel = x_q.bsel;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `EBR_CTRL_RST;
         unit_q <= 3'h0;
         src_q <= 15'h0000;
         dst_q <= 15'h0000;
         cnt_q <= `EBR_CNT_RST;
         dig_q <= 4'h0;
         maddr_q <= 15'h0000;
         done_q <= 1'b0;
         err_q <= 1'b0;
         st_q <= ebr_pkg::ST_IDLE;
         x_q <= '0;
         iss_q <= 15'h0000;
         wr_q <= 15'h0000;
         req_q <= 1'b0;
         ea_q <= 15'h0000;
         en_prev_q <= 1'b0;
         scan_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;
         unit_q <= unit_d;
         src_q <= src_d;
         dst_q <= dst_d;
         cnt_q <= cnt_d;
         dig_q <= dig_d;
         maddr_q <= maddr_d;
         done_q <= done_d;
         err_q <= err_d;
         st_q <= st_d;
         x_q <= x_d;
         iss_q <= iss_d;
         wr_q <= wr_d;
         req_q <= req_d;
         ea_q <= ea_d;
         en_prev_q <= ctrl_q[`EBR_CTRL_EN];
         scan_q <= scan_d;
      end
   end

   ebr_fifo #(.W(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(aclk),
      .rst_n(aresetn),
      .in_s(fin),
      .out_s(fout)
   );

   ebr_wordmem #(.AW(DST_AW)) u_mem (
      .clk(aclk),
      .we(mem_we),
      .waddr(DST_AW'(x_q.dst + wr_q)),
      .wdata(fout.data),
      .wmask(mem_mask),
      .raddr(maddr_q[DST_AW-1:0]),
      .rdata(mem_rdata)
   );
endmodule : ebr_engine

// ---- sim/ebr_checker.sv ----
// Concurrent checks on the read engine ports
`timescale 1ns/1ps
module ebr_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic ext_req,
   input wire logic ext_ack,
   input wire logic [14:0] ext_addr,
   input wire logic irq_active,
   input wire logic irq_hold,
   input wire logic busy
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   req_hold_a: assert property (
      ext_req && !ext_ack |=> ext_req && $stable(ext_addr))
      else $error("read request changed before ack");
   req_gap_a: assert property (
      ext_req && ext_ack |=> !ext_req)
      else $error("request not dropped after ack");
   addr_step_a: assert property (
      ext_req && ext_ack ##2 ext_req && busy
      |-> ext_addr == $past(ext_addr, 2) + 15'h0001)
      else $error("buffer index did not step by one");
   req_busy_a: assert property (ext_req |-> busy)
      else $error("request outside a transfer");
   hold_idle_a: assert property (irq_hold |-> busy)
      else $error("interrupts held while idle");
   pause_a: assert property (
      busy && !irq_hold && irq_active && !ext_req |=> !ext_req)
      else $error("request issued during interrupt");
   bresp_time_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   rresp_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
endmodule : ebr_checker

bind ebr_engine ebr_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .ext_req(ext_req), .ext_ack(ext_ack), .ext_addr(ext_addr),
   .irq_active(irq_active), .irq_hold(irq_hold), .busy(busy));

// ---- sim/ebr_bus_model.sv ----
// Extension unit buffer memory answering read requests
`timescale 1ns/1ps
module ebr_bus_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ext_req,
   input wire logic [2:0] ext_slot,
   input wire logic ext_builtin_sel,
   input wire logic [14:0] ext_addr,
   input wire logic [3:0] lag,
   output logic ext_ack,
   output logic [15:0] ext_rdata
);
   logic [3:0] wait_q;
   always @(posedge aclk) begin
      // Data is not driven outside an ack, so it keeps toggling
      if (aresetn && !ext_ack && ext_req && wait_q >= lag) begin
         ext_rdata <= {ext_builtin_sel, ext_slot, ext_addr[11:0]};
      end else begin
         ext_rdata <= ~ext_rdata;
      end
      if (!aresetn) begin
         ext_ack <= 1'b0;
         wait_q <= 4'h0;
      end else if (ext_ack || !ext_req) begin
         ext_ack <= 1'b0;
         wait_q <= 4'h0;
      end else if (wait_q >= lag) begin
         ext_ack <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end
endmodule : ebr_bus_model

// ---- sim/ebr_engine_tb.sv ----
// Self-checking bench for the buffer read engine
`timescale 1ns/1ps
`include "ebr_params.svh"
module ebr_engine_tb;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF, lag = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic irq_active = 1'b0, in_isr = 1'b0, builtin_strap = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, ext_req, ext_builtin_sel, ext_ack, irq_hold, busy;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic [2:0] ext_slot;
   logic [14:0] ext_addr;
   logic [15:0] ext_rdata;
   int fail_count = 0, compares = 0, acks = 0, a0 = 0;
   logic [31:0] tc [7][5] = '{'{3, 0, 0, 0, 1}, '{7, 0, 32'h4000, 0, 1},
      '{7, 32'h7FFE, 1, 0, 1}, '{7, 32'h7FFD, 1, 0, 0},
      '{3, 32'h7FFE, 1, 0, 0}, '{3, 0, 1, 5, 1}, '{7, 0, 1, 8, 0}};

   ebr_engine #(.SCAN_DIV(20)) dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .ext_req(ext_req), .ext_slot(ext_slot),
      .ext_builtin_sel(ext_builtin_sel), .ext_addr(ext_addr),
      .ext_ack(ext_ack), .ext_rdata(ext_rdata), .irq_active(irq_active),
      .in_isr(in_isr), .irq_hold(irq_hold), .builtin_strap(builtin_strap),
      .busy(busy));
   ebr_bus_model u_unit (.aclk(aclk), .aresetn(aresetn), .ext_req(ext_req),
      .ext_slot(ext_slot), .ext_builtin_sel(ext_builtin_sel),
      .ext_addr(ext_addr), .lag(lag), .ext_ack(ext_ack),
      .ext_rdata(ext_rdata));

   always #20 aclk = ~aclk;
   always @(posedge aclk) if (ext_req && ext_ack) acks <= acks + 1;

   task automatic chk(input string nm, input logic [31:0] s, e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   // Readies are sampled mid-cycle, where nothing is changing
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
         input logic [1:0] er = 2'h0);
      logic ta, tw, tb;
      logic [1:0] rs;
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, rs}, {30'h0, er});
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
         output logic [1:0] rs);
      logic ta, tr;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      tr = 1'b0;
      while (!tr) begin
         @(negedge aclk);
         ta = s_axi_arready;
         tr = s_axi_rvalid;
         v = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task automatic cfg(input logic [31:0] ctl, u, s, dst, n, dg);
      wr(`EBR_OFF_UNIT, u);
      wr(`EBR_OFF_SRC, s);
      wr(`EBR_OFF_DST, dst);
      wr(`EBR_OFF_CNT, n);
      wr(`EBR_OFF_DIG, dg);
      wr(`EBR_OFF_CTRL, ctl);
   endtask : cfg

   task automatic fin(input logic er);
      logic [31:0] st;
      logic [1:0] rs;
      st = 32'h0;
      while (st[2:1] == 2'b00) rd(`EBR_OFF_STAT, st, rs);
      chk("err_flag", {31'h0, st[2]}, {31'h0, er});
      wr(`EBR_OFF_STAT, 32'h6);
      wr(`EBR_OFF_CTRL, 32'h0);
   endtask : fin

   task automatic mchk(input logic [31:0] a, input logic [15:0] e);
      wr(`EBR_OFF_MADDR, a);
      rd(`EBR_OFF_MDATA, d, r);
      chk("stored_word", d, {16'h0, e});
   endtask : mchk

   task automatic final_report;
      if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report

   initial begin
      repeat (60000) @(posedge aclk);
      fail_count++;
      final_report;
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      rd(`EBR_OFF_CTRL, d, r);
      chk("ctrl_reset", d, 32'h0);
      rd(`EBR_OFF_CNT, d, r);
      chk("cnt_reset", d, 32'h1);
      rd(8'h40, d, r);
      chk("unmapped_resp", {d[29:0], r}, 32'h2);
      wr(`EBR_OFF_MDATA, 32'h1, 2'h2);
      cfg(3, 3, 10, 0, 5, 0);
      fin(0);
      for (int i = 0; i < 5; i++) mchk(i, {4'h3, 12'(10 + i)});
      a0 = acks;
      wr(`EBR_OFF_CTRL, 32'h3);
      repeat (80) @(posedge aclk);
      chk("pulsed_once", 32'(acks - a0), 32'h5);
      wr(`EBR_OFF_STAT, 32'h6);
      wr(`EBR_OFF_CTRL, 32'h0);
      lag <= 4'h3;
      cfg(7, 1, 20, 8, 2, 0);
      fin(0);
      for (int i = 0; i < 4; i++) mchk(8 + i, {4'h1, 12'(20 + i)});
      // Drain frozen: the buffer fills and further reads must wait
      lag <= 4'h0;
      a0 = acks;
      cfg(32'h13, 2, 0, 16, 20, 0);
      repeat (150) @(posedge aclk);
      chk("fifo_full", 32'(acks - a0), 32'h10);
      wr(`EBR_OFF_CTRL, 32'h3);
      fin(0);
      chk("fifo_drain", 32'(acks - a0), 32'h14);
      cfg(3, 3, 40, 0, 1, 1);
      fin(0);
      mchk(0, 16'h3008);
      for (int i = 0; i < 7; i++) begin
         cfg(tc[i][0], 5, tc[i][1], 100, tc[i][2], tc[i][3]);
         fin(tc[i][4][0]);
      end
      in_isr <= 1'b1;
      irq_active <= 1'b1;
      lag <= 4'h2;
      cfg(3, 0, 0, 32, 4, 0);
      while (!busy) @(posedge aclk);
      @(negedge aclk);
      chk("irq_hold", {31'h0, irq_hold}, 32'h1);
      @(posedge aclk);
      fin(0);
      cfg(32'hB, 0, 0, 32, 4, 0);
      fin(1);
      in_isr <= 1'b0;
      a0 = acks;
      cfg(32'hB, 0, 0, 40, 4, 0);
      repeat (20) @(posedge aclk);
      rd(`EBR_OFF_STAT, d, r);
      chk("paused", d, 32'h9);
      chk("paused_reads", 32'(acks - a0), 32'h0);
      irq_active <= 1'b0;
      fin(0);
      a0 = acks;
      cfg(1, 4, 5, 48, 1, 0);
      repeat (100) @(posedge aclk);
      wr(`EBR_OFF_CTRL, 32'h0);
      repeat (30) @(posedge aclk);
      chk("plain_repeats", {31'h0, (acks - a0) >= 3}, 32'h1);
      wr(`EBR_OFF_STAT, 32'h6);
      builtin_strap <= 1'b1;
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
      rd(`EBR_OFF_STAT, d, r);
      chk("builtin_flag", d, 32'h10);
      cfg(3, 0, 2, 60, 1, 0);
      fin(0);
      mchk(60, 16'hF002);
      cfg(3, 2, 2, 61, 1, 0);
      fin(0);
      mchk(61, 16'h1002);
      final_report;
   end
endmodule : ebr_engine_tb
